// ### dv/lfp_flash_model.sv
// flash partner: follows the power request after a settling delay
`timescale 1ns/1ps
module lfp_flash_model (
  input  wire       sys_clk,
  input  wire [3:0] dly,
  input  wire       req,
  output reg        ack
);
  int n = 0;
  initial ack = 1'h0;
  // a request withdrawn early never reaches the low state
  always @(posedge sys_clk) begin
    if (req == ack) begin
      n <= 0;
    end else if (n >= dly) begin
      ack <= req;
      n <= 0;
    end else begin
      n <= n + 1;
    end
  end
endmodule

// ### dv/lfp_mode_ctrl_monitor.sv
// checker for the mode controller ports
`timescale 1ns/1ps
module lfp_mode_ctrl_monitor #(parameter LARGE_CORE = 0) (
  input wire sys_clk,
  input wire srst,
  input wire flash_pwr_req,
  input wire fetch_bus_err,
  input wire core_run,
  input wire machine_check,
  input wire checkstop_reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_entry;
    $fell(core_run) && !$past(fetch_bus_err) |-> flash_pwr_req;
  endproperty
  a_entry: assert property (p_entry) else $error("run left without flash request");
  property p_fault;
    fetch_bus_err && core_run |=> machine_check != checkstop_reset;
  endproperty
  a_fault: assert property (p_fault) else $error("fetch error not handled");
  property p_large;
    fetch_bus_err && core_run && LARGE_CORE != 0 |=> machine_check;
  endproperty
  a_large: assert property (p_large) else $error("large core missed machine check");
  property p_mc_pulse;
    machine_check |=> !machine_check;
  endproperty
  a_mc_pulse: assert property (p_mc_pulse) else $error("machine check too long");
  property p_cs_cause;
    checkstop_reset |-> $past(fetch_bus_err) && LARGE_CORE == 0;
  endproperty
  a_cs_cause: assert property (p_cs_cause) else $error("checkstop without cause");
  property p_fast;
    $rose(core_run) |-> !flash_pwr_req;
  endproperty
  a_fast: assert property (p_fast) else $error("run resumed with request up");
  // lowp exit must see the flash come back first
  property p_wait;
    $fell(flash_pwr_req) && !core_run |-> !core_run [*3];
  endproperty
  a_wait: assert property (p_wait) else $error("run before flash power up");
  property p_back;
    $fell(flash_pwr_req) |-> ##[0:40] core_run;
  endproperty
  a_back: assert property (p_back) else $error("run not resumed");
endmodule
bind lfp_mode_ctrl lfp_mode_ctrl_monitor #(.LARGE_CORE(LARGE_CORE)) mon_u (
  .sys_clk(sys_clk), .srst(srst), .flash_pwr_req(flash_pwr_req),
  .fetch_bus_err(fetch_bus_err), .core_run(core_run),
  .machine_check(machine_check), .checkstop_reset(checkstop_reset));

// ### dv/tb_lowpower_flash_power_handshake.sv
// testbench for the mode controller and flash handshake
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
  samples_checked++; \
  if ((s) !== (e)) begin \
    err_count++; \
    $display("wrong value %s exp %0h got %0h", n, e, s); \
  end \
end
module tb_lowpower_flash_power_handshake;
  reg        sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  reg        wake = 0, irq = 0, fosc = 0, ferr = 0, err_q;
  reg [7:0]  paddr = 8'h00;
  reg [31:0] pwdata = 32'h0, rv;
  reg [3:0]  dly = 4'h8;
  reg [15:0] lf = 16'h000E;
  wire [31:0] prdata;
  wire [1:0]  fmode;
  wire        pready, pslverr, req, ack, run, mc, cs;
  int         err_count = 0, samples_checked = 0, cyc = 0, i;
  lfp_mode_ctrl dut_u (.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_pwr_req(req), .flash_pwr_mode(fmode), .flash_pwr_ack(ack),
    .wakeup_signal(wake), .irq_pending(irq), .fosc_tick(fosc), .fetch_bus_err(ferr),
    .core_run(run), .machine_check(mc), .checkstop_reset(cs));
  lfp_flash_model fl_u (.sys_clk(sys_clk), .dly(dly), .req(req), .ack(ack));
  initial forever #12.5 sys_clk = ~sys_clk;
  function [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task stop_test;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // oscillator ticks on clock edges keep its edges clear of sampling
  always @(posedge sys_clk) begin
    fosc <= ~fosc;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test;
    end
  end
  task apb(input [7:0] a, input w, input [31:0] d);
    int t;
    @(posedge sys_clk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'h1 && t < 16);
    rv = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  reg dn = 1'h0;
  // first see run drop, so a check cannot pass before entry
  task wrun(input int lim);
    int t;
    t = 0;
    while (run !== 1'h0 && t < 8) begin
      @(posedge sys_clk);
      t++;
    end
    dn = (run === 1'h0);
    t = 0;
    while (run !== 1'h1 && t < lim) begin
      @(posedge sys_clk);
      t++;
    end
  endtask
  task fault;
    @(posedge sys_clk);
    ferr <= 1'h1;
    @(posedge sys_clk);
    ferr <= 1'h0;
    #1;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'h0;
    apb(8'h04, 0, 0);
    `CHK("stat", 32'h23, rv)
    apb(8'h18, 0, 0);
    `CHK("slverr", 1'h1, err_q)
    // full power-down entry, woken late
    apb(8'h00, 1, 32'h0B);
    apb(8'h04, 0, 0);
    `CHK("flags", 2'h3, rv[1:0])
    `CHK("mode", 2'h2, fmode)
    `CHK("run", 1'h0, run)
    for (i = 0; i < 20 && rv[4:3] !== 2'h2; i++) apb(8'h04, 0, 0);
    apb(8'h04, 0, 0);
    `CHK("lowflags", 2'h0, rv[1:0])
    wake <= 1'h1;
    wrun(100);
    wake <= 1'h0;
    `CHK("runlate", 1'h1, run)
    apb(8'h04, 0, 0);
    `CHK("stat2", 8'h23, rv[7:0])
    // early wake: flash never powers down
    dly <= 4'hC;
    apb(8'h00, 1, 32'h0B);
    irq <= 1'h1;
    wrun(12);
    irq <= 1'h0;
    `CHK("entfast", 1'h1, dn)
    `CHK("runfast", 1'h1, run)
    `CHK("ack", 1'h0, ack)
    fault;
    `CHK("cstop", 2'h1, {mc, cs})
    apb(8'h08, 1, 32'h1);
    fault;
    `CHK("mcheck", 2'h2, {mc, cs})
    apb(8'h0C, 0, 0);
    `CHK("event", 32'hF, rv)
    apb(8'h0C, 1, 32'hF);
    apb(8'h0C, 0, 0);
    `CHK("evclr", 32'h0, rv)
    // resync: flash to low power in run, then back to normal
    apb(8'h00, 1, 32'h05);
    @(posedge sys_clk);
    #1;
    `CHK("rsreq", 3'h5, {req, fmode})
    apb(8'h00, 1, 32'h01);
    @(posedge sys_clk);
    #1;
    `CHK("rsoff", 1'h0, req)
    // timer wake with bypassed prescalers over small timeouts
    dly <= 4'h6;
    for (i = 0; i < 4; i++) begin
      lf = nx(lf);
      apb(8'h14, 1, 32'd4 + lf % 27);
      apb(8'h10, 1, 32'h1F);
      apb(8'h00, 1, 32'h0B);
      wrun(400);
      `CHK("tmentry", 1'h1, dn)
      `CHK("tmwake", 1'h1, run)
      apb(8'h10, 1, 32'h0);
    end
    stop_test;
  end
endmodule

// ### logic/lfp_defines.vh
// constants for the low-power flash power handshake block
`ifndef LFP_DEFINES_VH
`define LFP_DEFINES_VH

// register byte offsets
`define LFP_OFS_MODE_CTL    8'h00
`define LFP_OFS_MODE_STAT   8'h04
`define LFP_OFS_CORE_CFG    8'h08
`define LFP_OFS_EVENT       8'h0C
`define LFP_OFS_TMR_CTL     8'h10
`define LFP_OFS_TMR_VAL     8'h14

// mode control fields
`define LFP_MC_GO           0
`define LFP_MC_LOWP         1
`define LFP_MC_FCFG_LO      2
`define LFP_MC_FCFG_HI      3

// flash power configurations
`define LFP_FLASH_NORMAL    2'h0
`define LFP_FLASH_LOWPWR    2'h1
`define LFP_FLASH_PWRDN     2'h2

// event flag positions
`define LFP_EV_CHECKSTOP    0
`define LFP_EV_MCHECK       1
`define LFP_EV_GAPWAKE      2
`define LFP_EV_BUSERR       3

// timer control fields
`define LFP_TC_EN           0
`define LFP_TC_FOSC         1
`define LFP_TC_BYP512       2
`define LFP_TC_BYP32        3
`define LFP_TC_SRC0         4

// reset values
`define LFP_RST_MODE_CTL    4'h0
`define LFP_RST_CORE_CFG    1'h0
`define LFP_RST_TMR_CTL     5'h00
`define LFP_RST_TMR_VAL     16'h0000
`define LFP_RST_FLAGS       2'h3

// timing counts
`define LFP_SYNC_STAGES     2
`define LFP_GAP_MIN_CYC     2
`define LFP_GAP_MAX_CYC     4
`define LFP_PRE_A_DIV       512
`define LFP_PRE_B_DIV       32

`endif

// ### logic/lfp_mode_ctrl.v
// mode controller with flash power handshake and fetch error handling
`timescale 1ns/1ps
`include "lfp_defines.vh"

module lfp_mode_ctrl #(
  parameter LARGE_CORE = 0,
  parameter VAL_W      = 16
) (
  input  wire        sys_clk,
  input  wire        srst,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg         flash_pwr_req,
  output reg  [1:0]  flash_pwr_mode,
  input  wire        flash_pwr_ack,
  input  wire        wakeup_signal,
  input  wire        irq_pending,
  input  wire        fosc_tick,
  input  wire        fetch_bus_err,
  output reg         core_run,
  output reg         machine_check,
  output reg         checkstop_reset
);

  localparam ST_RUN   = 2'h0;
  localparam ST_ENTER = 2'h1;
  localparam ST_LOWP  = 2'h2;
  localparam ST_EXIT  = 2'h3;

  localparam [1:0] RST_FLAGS = `LFP_RST_FLAGS;

  // address decode, shared by the slave error and the write enable
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `LFP_OFS_MODE_CTL) | (a == `LFP_OFS_MODE_STAT)
                  | (a == `LFP_OFS_CORE_CFG) | (a == `LFP_OFS_EVENT)
                  | (a == `LFP_OFS_TMR_CTL) | (a == `LFP_OFS_TMR_VAL);
    end
  endfunction

  // flash configuration field of the mode control word
  function [1:0] flash_cfg;
    input [3:0] m;
    begin
      flash_cfg = m[`LFP_MC_FCFG_HI:`LFP_MC_FCFG_LO];
    end
  endfunction

  reg  [1:0]       state_q;
  reg  [1:0]       state_d;
  reg              req_d;
  reg  [1:0]       pmode_d;
  reg              run_d;
  reg  [3:0]       mode_ctl_q;
  reg              mce_q;
  reg  [4:0]       tmr_ctl_q;
  reg  [VAL_W-1:0] tmr_val_q;
  reg  [3:0]       event_q;
  reg  [3:0]       event_set;
  reg              code_flash_state_flag_q;
  reg              data_flash_state_flag_q;
  reg  [1:0]       run_fcfg_q;
  reg  [1:0]       ack_sync_q;
  reg              ack_prev_q;
  reg  [1:0]       wk_sync_q;
  reg  [1:0]       fosc_sync_q;
  reg              fosc_prev_q;
  reg              go_q;
  reg              gap_wake;

  wire             wr_en;
  wire             rd_en;
  wire             addr_hit;
  wire             ack_s;
  wire             ack_edge;
  wire             tmr_wake;
  wire             wake_any;
  wire             fosc_rise;
  wire             err_mcheck;

  // two flops on the flash acknowledge, this is where the gap comes from
  always @(posedge sys_clk) begin
    if (srst) begin
      ack_sync_q <= 2'h0;
      ack_prev_q <= 1'b0;
    end else begin
      ack_sync_q <= {ack_sync_q[0], flash_pwr_ack};
      ack_prev_q <= ack_sync_q[1];
    end
  end

  // wake pin is asynchronous to the system clock
  always @(posedge sys_clk) begin
    if (srst) begin
      wk_sync_q <= 2'h0;
    end else begin
      wk_sync_q <= {wk_sync_q[0], wakeup_signal};
    end
  end

  // only rising edges count, so the pin must toggle below half the clock
  always @(posedge sys_clk) begin
    if (srst) begin
      fosc_sync_q <= 2'h0;
      fosc_prev_q <= 1'b0;
    end else begin
      fosc_sync_q <= {fosc_sync_q[0], fosc_tick};
      fosc_prev_q <= fosc_sync_q[1];
    end
  end

  assign ack_s     = ack_sync_q[1];
  assign ack_edge  = ack_s ^ ack_prev_q;
  assign fosc_rise = fosc_sync_q[1] & ~fosc_prev_q;

  lfp_wake_timer #(
    .VAL_W (VAL_W)
  ) u_timer (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .enable     (tmr_ctl_q[`LFP_TC_EN]),
    .fosc_sel   (tmr_ctl_q[`LFP_TC_FOSC]),
    .fosc_tick  (fosc_rise),
    .byp_512    (tmr_ctl_q[`LFP_TC_BYP512]),
    .byp_32     (tmr_ctl_q[`LFP_TC_BYP32]),
    .timeout    (tmr_val_q),
    .wake_pulse (tmr_wake)
  );

  // timer wakes only when routed to wakeup source zero
  assign wake_any = wk_sync_q[1] | irq_pending
                    | (tmr_wake & tmr_ctl_q[`LFP_TC_SRC0]);

  // APB slave, zero wait states
  assign pready   = 1'b1;
  assign addr_hit = is_mapped(paddr);
  assign pslverr  = psel & penable & ~addr_hit;
  assign wr_en    = psel & penable & pwrite & addr_hit;
  assign rd_en    = psel & ~penable & ~pwrite;

  always @(posedge sys_clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        `LFP_OFS_MODE_CTL: prdata <= {28'h0000000, mode_ctl_q};
        `LFP_OFS_MODE_STAT: prdata <= {24'h000000, run_fcfg_q, core_run,
                                       state_q, flash_pwr_req,
                                       data_flash_state_flag_q,
                                       code_flash_state_flag_q};
        `LFP_OFS_CORE_CFG: prdata <= {31'h00000000, mce_q};
        `LFP_OFS_EVENT: prdata <= {28'h0000000, event_q};
        `LFP_OFS_TMR_CTL: prdata <= {27'h0000000, tmr_ctl_q};
        `LFP_OFS_TMR_VAL: prdata <= {{(32-VAL_W){1'b0}}, tmr_val_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      mode_ctl_q <= `LFP_RST_MODE_CTL;
      mce_q      <= `LFP_RST_CORE_CFG;
      tmr_ctl_q  <= `LFP_RST_TMR_CTL;
      tmr_val_q  <= {VAL_W{1'b0}};
      go_q       <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (wr_en) begin
        case (paddr)
          `LFP_OFS_MODE_CTL: begin
            mode_ctl_q <= {pwdata[3:1], 1'b0};
            go_q       <= pwdata[`LFP_MC_GO];
          end
          `LFP_OFS_CORE_CFG: mce_q <= pwdata[0];
          `LFP_OFS_TMR_CTL: tmr_ctl_q <= pwdata[4:0];
          `LFP_OFS_TMR_VAL: tmr_val_q <= pwdata[VAL_W-1:0];
          default: go_q <= 1'b0;
        endcase
      end
    end
  end

  // mode sequencer
  always @* begin
    state_d  = state_q;
    req_d    = flash_pwr_req;
    pmode_d  = flash_pwr_mode;
    run_d    = core_run;
    gap_wake = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (go_q) begin
          if (mode_ctl_q[`LFP_MC_LOWP]) begin
            // ask the flash for the configured mode and stop the core in the same cycle
            req_d   = 1'b1;
            pmode_d = flash_cfg(mode_ctl_q);
            run_d   = 1'b0;
            state_d = ST_ENTER;
          end else begin
            // run-mode flash change, used to resync the flash
            req_d   = (flash_cfg(mode_ctl_q) != `LFP_FLASH_NORMAL);
            pmode_d = flash_cfg(mode_ctl_q);
          end
        end
      end
      ST_ENTER: begin
        if (wake_any & ~ack_s) begin
          // acknowledge not seen yet: flash assumed up
          req_d    = 1'b0;
          pmode_d  = `LFP_FLASH_NORMAL;
          run_d    = 1'b1;
          gap_wake = 1'b1;
          state_d  = ST_RUN;
        end else if (ack_s) begin
          state_d = ST_LOWP;
        end
      end
      ST_LOWP: begin
        if (wake_any) begin
          req_d   = 1'b0;
          pmode_d = `LFP_FLASH_NORMAL;
          state_d = ST_EXIT;
        end
      end
      ST_EXIT: begin
        // stay low until flash reports powered up again
        if (~ack_s) begin
          run_d   = 1'b1;
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
        req_d   = 1'b0;
        pmode_d = `LFP_FLASH_NORMAL;
        run_d   = 1'b1;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      state_q        <= ST_RUN;
      flash_pwr_req  <= 1'b0;
      flash_pwr_mode <= `LFP_FLASH_NORMAL;
      core_run       <= 1'b1;
    end else begin
      state_q        <= state_d;
      flash_pwr_req  <= req_d;
      flash_pwr_mode <= pmode_d;
      core_run       <= run_d;
    end
  end

  // flags move only on an acknowledge edge, never on the request
  always @(posedge sys_clk) begin
    if (srst) begin
      code_flash_state_flag_q <= RST_FLAGS[0];
      data_flash_state_flag_q <= RST_FLAGS[1];
      run_fcfg_q              <= `LFP_FLASH_NORMAL;
    end else if (ack_edge) begin
      code_flash_state_flag_q <= ~ack_s;
      data_flash_state_flag_q <= ~ack_s;
      run_fcfg_q              <= ack_s ? flash_pwr_mode : `LFP_FLASH_NORMAL;
    end
  end

  // fetch fault handling; no checkstop on the large core
  assign err_mcheck = (LARGE_CORE != 0) | mce_q;

  always @(posedge sys_clk) begin
    if (srst) begin
      machine_check <= 1'b0;
    end else begin
      machine_check <= fetch_bus_err & core_run & err_mcheck;
    end
  end

  // unhandled fault leads to the normal reset path
  always @(posedge sys_clk) begin
    if (srst) begin
      checkstop_reset <= 1'b0;
    end else begin
      checkstop_reset <= fetch_bus_err & core_run & ~err_mcheck;
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always @* begin
    event_set                     = 4'h0;
    event_set[`LFP_EV_CHECKSTOP]  = checkstop_reset;
    event_set[`LFP_EV_MCHECK]     = machine_check;
    event_set[`LFP_EV_GAPWAKE]    = gap_wake;
    event_set[`LFP_EV_BUSERR]     = fetch_bus_err & core_run;
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      event_q <= 4'h0;
    end else if (wr_en & (paddr == `LFP_OFS_EVENT)) begin
      event_q <= (event_q & ~pwdata[3:0]) | event_set;
    end else begin
      event_q <= event_q | event_set;
    end
  end

endmodule

// ### logic/lfp_wake_timer.v
// periodic wake timer with bypassable prescalers
`timescale 1ns/1ps
`include "lfp_defines.vh"

module lfp_wake_timer #(
  parameter VAL_W = 16
) (
  input  wire             sys_clk,
  input  wire             srst,
  input  wire             enable,
  input  wire             fosc_sel,
  input  wire             fosc_tick,
  input  wire             byp_512,
  input  wire             byp_32,
  input  wire [VAL_W-1:0] timeout,
  output reg              wake_pulse
);

  reg  [8:0]       pre_a_q;
  reg  [4:0]       pre_b_q;
  reg  [VAL_W-1:0] cnt_q;
  wire             src_tick;
  wire             a_tick;
  wire             b_tick;

  // source is the system clock or the fast oscillator tick
  assign src_tick = fosc_sel ? fosc_tick : 1'b1;
  assign a_tick = src_tick & (byp_512 | (pre_a_q == 9'h1FF));
  assign b_tick = a_tick & (byp_32 | (pre_b_q == 5'h1F));

  always @(posedge sys_clk) begin
    if (srst | ~enable) begin
      pre_a_q    <= 9'h000;
      pre_b_q    <= 5'h00;
      cnt_q      <= {VAL_W{1'b0}};
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= 1'b0;
      if (src_tick) begin
        pre_a_q <= pre_a_q + 9'h001;
      end
      if (a_tick) begin
        pre_b_q <= pre_b_q + 5'h01;
      end
      if (b_tick) begin
        // timeout of zero fires every tick
        if (cnt_q >= timeout) begin
          cnt_q      <= {VAL_W{1'b0}};
          wake_pulse <= 1'b1;
        end else begin
          cnt_q <= cnt_q + {{(VAL_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule
